/* File: include/mode_sel_pkg.sv */
package mode_sel_pkg;

  // Mode pin codes, ordered c,b,a
  localparam logic [2:0] MODE_CODE_NSC = 3'h4;
  localparam logic [2:0] MODE_CODE_SSC = 3'h0;
  localparam logic [2:0] MODE_CODE_ESC = 3'h1;
  localparam logic [2:0] MODE_CODE_NX = 3'h5;
  localparam logic [2:0] MODE_CODE_EX = 3'h3;
  localparam logic [2:0] MODE_CODE_ST = 3'h2;

  // Decoded chip modes, one-hot
  typedef enum logic [6:0] {
    MODE_NORM_SINGLE = 7'h01,
    MODE_SPEC_SINGLE = 7'h02,
    MODE_EMUL_SINGLE = 7'h04,
    MODE_NORM_EXP = 7'h08,
    MODE_EMUL_EXP = 7'h10,
    MODE_SPEC_TEST = 7'h20,
    MODE_INVALID = 7'h40
  } chip_mode_t;

  // Data sources, one-hot
  typedef enum logic [3:0] {
    SRC_INTERNAL = 4'h1,
    SRC_INT_FLASH = 4'h2,
    SRC_EMUL_MEM = 4'h4,
    SRC_EXTERNAL = 4'h8
  } data_src_t;

  // Wishbone register map (byte addresses)
  localparam logic [7:0] ADDR_MEM_MAP_CTL = 8'h00;
  localparam logic [7:0] ADDR_MODE_STATUS = 8'h04;
  localparam logic [7:0] ADDR_BUS_CTL = 8'h08;

  // memory_map_control_one field positions
  localparam int BIT_INT_FLASH_EN = 0;
  localparam int BIT_EMUL_FLASH_EN = 1;
  // Bus control field positions
  localparam int BIT_BUS_DIV_LO = 0;
  localparam int BUS_DIV_W = 4;

  // Divider reset value and minimum
  localparam logic [3:0] BUS_DIV_RST = 4'h2;
  localparam logic [3:0] BUS_DIV_MIN = 4'h2;

  // Widths of the expanded bus
  localparam int EXT_ADDR_W = 23;
  localparam int EXT_DATA_W = 16;

  // Port usage of the expanded bus
  typedef struct packed {
    logic addr_bus_en;
    logic data_bus_en;
    logic bus_ctl_en;
    logic visible_bus;
    logic gpio_en;
  } port_cfg_t;

endpackage

/* File: hw/bus_rate_div.sv */
`timescale 1ns/1ps
// External bus strobe divider, never faster than half the internal clock
module bus_rate_div #(
  parameter int DIV_W = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic [DIV_W-1:0] div_i,
  output logic tick_o
);

  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] cnt_d;
  logic tick_q;
  logic tick_d;

  // Count down, tick on wrap
  always_comb
  begin
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (!en_i)
    begin
      cnt_d = '0;
    end
    else if (cnt_q == '0)
    begin
      cnt_d = div_i - DIV_W'(1);
      tick_d = 1'b1;
    end
    else
    begin
      cnt_d = cnt_q - DIV_W'(1);
    end
  end

  // Counter registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;

endmodule

/* File: hw/chip_mode_sel.sv */
// Register access over Wishbone and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// How it works
// RULE_01 - Latch flash select into internal flash enable
// RULE_02 - Latch emulation flash select into its enable
// RULE_03 - Decode mode pins c,b,a into chip modes
// RULE_04 - Normal and special single-chip modes always use internal resources
// RULE_05 - Emulation memory in listed emulation cases
// RULE_06 - Peripheral, RAM, EEPROM, registers stay internal; code only redirects them away from emulation memory
// RULE_07 - Expanded and test modes: external or flash
// RULE_08 - Internal flash in listed emulation cases
// RULE_09 - Normal expanded: ports K,A,B 23-bit address
// RULE_10 - Normal expanded: C,D data, E control
// RULE_11 - External bus at most half internal rate
// RULE_12 - Normal single-chip: no bus, ports GPIO
// RULE_13 - Special single-chip enables debug monitor
// RULE_14 - Special single-chip: no external bus
// RULE_15 - Emulation expanded fetch follows flash bits
// RULE_16 - Emulation expanded shows internal bus externally
// RULE_17 - Sample pins at reset release, hold
module chip_mode_sel #(
  parameter int DIV_W = mode_sel_pkg::BUS_DIV_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic mode_pin_a_i,
  input wire logic mode_pin_b_i,
  input wire logic mode_pin_c_i,
  input wire logic flash_select_pin_i,
  input wire logic emul_flash_select_pin_i,
  input wire logic internal_region_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [3:0] data_src_o,
  output mode_sel_pkg::port_cfg_t port_cfg_o,
  output logic debug_unit_en_o,
  output logic ext_bus_tick_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Reset-release capture

  logic rst_d1_q;
  logic rst_d1_d;
  logic [2:0] mode_pins_q;
  logic [2:0] mode_pins_d;
  logic int_flash_en_q;
  logic int_flash_en_d;
  logic emul_flash_en_q;
  logic emul_flash_en_d;
  logic release_edge;

  // Release is the first clock after rst_i falls
  always_comb
  begin
    rst_d1_d = rst_i;
    release_edge = rst_d1_q && !rst_i;
    mode_pins_d = mode_pins_q;
    int_flash_en_d = int_flash_en_q;
    emul_flash_en_d = emul_flash_en_q;
    if (release_edge)
    begin
      mode_pins_d = {mode_pin_c_i, mode_pin_b_i, mode_pin_a_i}; // [RULE_17]
      int_flash_en_d = flash_select_pin_i; // [RULE_01]
      emul_flash_en_d = emul_flash_select_pin_i; // [RULE_02]
    end
  end

  // Captured straps hold until next reset
  always_ff @(posedge clk_i)
  begin
    rst_d1_q <= rst_d1_d;
    if (rst_i)
    begin
      mode_pins_q <= mode_sel_pkg::MODE_CODE_NSC;
      int_flash_en_q <= 1'b0;
      emul_flash_en_q <= 1'b0;
    end
    else
    begin
      mode_pins_q <= mode_pins_d;
      int_flash_en_q <= int_flash_en_d;
      emul_flash_en_q <= emul_flash_en_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mode decode and data source

  mode_sel_pkg::chip_mode_t mode;
  mode_sel_pkg::data_src_t src;
  mode_sel_pkg::port_cfg_t cfg;
  logic dbg_en;

  // Mode pins to chip mode
  always_comb
  begin
    case (mode_pins_q) // [RULE_03]
      mode_sel_pkg::MODE_CODE_NSC: mode = mode_sel_pkg::MODE_NORM_SINGLE;
      mode_sel_pkg::MODE_CODE_SSC: mode = mode_sel_pkg::MODE_SPEC_SINGLE;
      mode_sel_pkg::MODE_CODE_ESC: mode = mode_sel_pkg::MODE_EMUL_SINGLE;
      mode_sel_pkg::MODE_CODE_NX: mode = mode_sel_pkg::MODE_NORM_EXP;
      mode_sel_pkg::MODE_CODE_EX: mode = mode_sel_pkg::MODE_EMUL_EXP;
      mode_sel_pkg::MODE_CODE_ST: mode = mode_sel_pkg::MODE_SPEC_TEST;
      default: mode = mode_sel_pkg::MODE_INVALID;
    endcase
  end

  // Data source and port usage per mode
  always_comb
  begin
    src = mode_sel_pkg::SRC_INTERNAL;
    cfg = '0;
    dbg_en = 1'b0;
    case (mode)
      mode_sel_pkg::MODE_NORM_SINGLE:
      begin
        src = mode_sel_pkg::SRC_INTERNAL; // [RULE_04]
        cfg.gpio_en = 1'b1; // [RULE_12]
      end
      mode_sel_pkg::MODE_SPEC_SINGLE:
      begin
        src = mode_sel_pkg::SRC_INTERNAL; // [RULE_04]
        dbg_en = 1'b1; // [RULE_13]
        // No external bus after reset, pins stay general-purpose
        cfg.addr_bus_en = 1'b0; // [RULE_14]
        cfg.data_bus_en = 1'b0; // [RULE_14]
        cfg.bus_ctl_en = 1'b0; // [RULE_14]
        cfg.gpio_en = 1'b1;
      end
      mode_sel_pkg::MODE_EMUL_SINGLE:
      begin
        if (emul_flash_en_q)
        begin
          src = mode_sel_pkg::SRC_INT_FLASH; // [RULE_08]
        end
        else
        begin
          src = mode_sel_pkg::SRC_EMUL_MEM; // [RULE_05]
        end
      end
      mode_sel_pkg::MODE_NORM_EXP, mode_sel_pkg::MODE_SPEC_TEST:
      begin
        src = int_flash_en_q ? mode_sel_pkg::SRC_INT_FLASH
                             : mode_sel_pkg::SRC_EXTERNAL; // [RULE_07]
        cfg.addr_bus_en = 1'b1; // [RULE_09]
        cfg.data_bus_en = 1'b1; // [RULE_10]
        cfg.bus_ctl_en = 1'b1; // [RULE_10]
      end
      mode_sel_pkg::MODE_EMUL_EXP:
      begin
        if (!int_flash_en_q)
        begin
          src = mode_sel_pkg::SRC_EXTERNAL; // [RULE_07] [RULE_15]
        end
        else if (emul_flash_en_q)
        begin
          src = mode_sel_pkg::SRC_INT_FLASH; // [RULE_08] [RULE_15]
        end
        else
        begin
          src = mode_sel_pkg::SRC_EMUL_MEM; // [RULE_05] [RULE_15]
        end
        cfg.addr_bus_en = 1'b1;
        cfg.data_bus_en = 1'b1;
        cfg.bus_ctl_en = 1'b1;
        cfg.visible_bus = 1'b1; // [RULE_16]
      end
      default:
      begin
        src = mode_sel_pkg::SRC_INTERNAL;
        cfg.gpio_en = 1'b1;
      end
    endcase
    // Core register, RAM and EEPROM space is kept off emulation memory; external and flash sources are left as decoded
    if (internal_region_i && src == mode_sel_pkg::SRC_EMUL_MEM)
    begin
      src = mode_sel_pkg::SRC_INTERNAL; // [RULE_06]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output registers

  logic [3:0] src_q;
  mode_sel_pkg::port_cfg_t cfg_q;
  logic dbg_q;

  // Registered data outputs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      src_q <= mode_sel_pkg::SRC_INTERNAL;
      cfg_q <= '0;
      dbg_q <= 1'b0;
    end
    else
    begin
      src_q <= src;
      cfg_q <= cfg;
      dbg_q <= dbg_en;
    end
  end

  assign data_src_o = src_q;
  assign port_cfg_o = cfg_q;
  assign debug_unit_en_o = dbg_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Wishbone slave

  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_d;
  logic ack_q;
  logic ack_d;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  logic access;

  // Decode, divider write and read mux
  always_comb
  begin
    access = wb_cyc_i && wb_stb_i && !ack_q;
    ack_d = access;
    div_d = div_q;
    rdat_d = rdat_q;
    if (access)
    begin
      rdat_d = 32'h0000_0000;
      if (wb_adr_i == mode_sel_pkg::ADDR_MEM_MAP_CTL)
      begin
        rdat_d[mode_sel_pkg::BIT_INT_FLASH_EN] = int_flash_en_q;
        rdat_d[mode_sel_pkg::BIT_EMUL_FLASH_EN] = emul_flash_en_q;
      end
      else if (wb_adr_i == mode_sel_pkg::ADDR_MODE_STATUS)
      begin
        rdat_d[2:0] = mode_pins_q;
        rdat_d[7:4] = src_q;
        rdat_d[12:8] = cfg_q;
        rdat_d[13] = dbg_q;
      end
      else if (wb_adr_i == mode_sel_pkg::ADDR_BUS_CTL)
      begin
        rdat_d[DIV_W-1:0] = div_q;
        if (wb_we_i && wb_sel_i[0])
        begin
          // Clamp to at least divide by two
          if (wb_dat_i[DIV_W-1:0] < DIV_W'(mode_sel_pkg::BUS_DIV_MIN))
          begin
            div_d = DIV_W'(mode_sel_pkg::BUS_DIV_MIN); // [RULE_11]
          end
          else
          begin
            div_d = wb_dat_i[DIV_W-1:0];
          end
        end
      end
    end
  end

  // Bus registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_q <= DIV_W'(mode_sel_pkg::BUS_DIV_RST);
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      div_q <= div_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  ////////////////////////////////////////////////////////////////////////////////
  // External bus rate

  bus_rate_div #(
    .DIV_W(DIV_W)
  ) u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(cfg_q.bus_ctl_en), // [RULE_11]
    .div_i(div_q),
    .tick_o(ext_bus_tick_o)
  );

endmodule

/* File: bench/chip_mode_sel_monitor.sv */
`timescale 1ns/1ps
// Port-level checks of bus handshake, sources and port setup
module chip_mode_sel_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic internal_region_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [3:0] data_src_o,
  input wire mode_sel_pkg::port_cfg_t port_cfg_o,
  input wire logic debug_unit_en_o,
  input wire logic ext_bus_tick_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_answers_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked");
  a_no_spurious_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  ////////////////////////////////////////////////////////////////////////////
  // Sources and port setup
  a_src_onehot: assert property ($onehot(data_src_o))
    else $error("source not one-hot");
  a_region_internal: assert property (internal_region_i |=> data_src_o != 4'h4)
    else $error("internal region sent to emulator");
  a_debug_no_bus: assert property (debug_unit_en_o |-> !port_cfg_o.addr_bus_en
    && !port_cfg_o.data_bus_en && !port_cfg_o.bus_ctl_en)
    else $error("bus active in debug mode");
  a_debug_internal: assert property (debug_unit_en_o |-> data_src_o == 4'h1)
    else $error("debug mode source not internal");
  a_tick_half_rate: assert property (ext_bus_tick_o |=> !ext_bus_tick_o)
    else $error("bus tick too fast");
  a_tick_needs_bus: assert property (ext_bus_tick_o |-> port_cfg_o.bus_ctl_en)
    else $error("tick with bus off");
  a_mode_held: assert property (!rst_i && !$past(rst_i) && !$past(rst_i, 2)
    && !$past(rst_i, 3) |-> $stable(port_cfg_o) && $stable(debug_unit_en_o))
    else $error("mode changed after reset");
endmodule

/* File: bench/ext_bus_model.sv */
`timescale 1ns/1ps
// Far-side bus device: measures strobe spacing on the expanded bus
module ext_bus_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  output logic [7:0] gap_o
);
  logic [7:0] cnt_q;
  // Cycles between the last two strobes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q <= 8'h00;
      gap_o <= 8'h00;
    end
    else if (tick_i)
    begin
      cnt_q <= 8'h00;
      gap_o <= cnt_q + 8'h01;
    end
    else
      cnt_q <= cnt_q + 8'h01;
  end
endmodule

/* File: bench/test_chip_mode_sel.sv */
`timescale 1ns/1ps
module test_chip_mode_sel;
  logic clk_i = 0, rst_i = 1, ma = 0, mb = 0, mc = 1, fs = 0, es = 0, reg_i = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, rd;
  logic we = 0, cyc = 0, stb = 0, ack, dbg, tick;
  logic [3:0] src;
  logic [7:0] gap;
  mode_sel_pkg::port_cfg_t pc;
  logic [2:0] codes [6] = '{3'h4, 3'h0, 3'h1, 3'h5, 3'h3, 3'h2};
  logic [2:0] m;
  logic [3:0] xs;
  logic [3:0] sel = 4'hF;
  int error_cnt = 0, check_count = 0;

  chip_mode_sel dut (.clk_i(clk_i), .rst_i(rst_i), .mode_pin_a_i(ma), .mode_pin_b_i(mb),
    .mode_pin_c_i(mc), .flash_select_pin_i(fs), .emul_flash_select_pin_i(es),
    .internal_region_i(reg_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
    .data_src_o(src), .port_cfg_o(pc), .debug_unit_en_o(dbg), .ext_bus_tick_o(tick));
  ext_bus_model far (.clk_i(clk_i), .rst_i(rst_i), .tick_i(tick), .gap_o(gap));

  // 10 MHz clock
  initial
  begin
    forever #50 clk_i = ~clk_i;
  end

  task results;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask

  // One classic Wishbone cycle, held until ack
  task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1; stb <= 1; adr <= a; we <= w; wdat <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1)
    begin
      error_cnt++;
      results();
    end
    rd = rdat;
    cyc <= 0; stb <= 0; we <= 0;
  endtask

  // Reset with straps, then flip straps after capture
  task boot(input logic [2:0] c, input logic f, input logic e);
    @(posedge clk_i);
    rst_i <= 1; {mc, mb, ma} <= c; fs <= f; es <= e;
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    @(posedge clk_i);
    {mc, mb, ma} <= ~c; fs <= ~f; es <= ~e;
    repeat (3) @(posedge clk_i);
  endtask

  function automatic logic [3:0] exp_src(logic [2:0] c, logic f, logic e);
    case (c)
      3'h1: return e ? 4'h2 : 4'h4;
      3'h3: return !f ? 4'h8 : (e ? 4'h2 : 4'h4);
      3'h5, 3'h2: return f ? 4'h2 : 4'h8;
      default: return 4'h1;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Every mode with every strap pair
  initial
  begin
    for (int i = 0; i < 24; i++)
    begin
      m = codes[i / 4];
      boot(m, i[1], i[0]);
      xs = exp_src(m, i[1], i[0]);
      wb(8'h00, 0, 0);
      chk(rd[1:0], {i[0], i[1]});
      wb(8'h04, 0, 0);
      chk(rd[2:0], m);
      chk(src, xs);
      chk(dbg, m == 3'h0);
      chk(pc[1], m == 3'h3);
      case (m)
        3'h5: chk(pc[4:2], 3'h7);
        3'h4: chk({pc[4], pc[0]}, 2'h1);
        3'h0: chk(pc[4:2], 3'h0);
        3'h3: chk(pc[1], 1'b1);
        default: ;
      endcase
      if (xs == 4'h4)
      begin
        reg_i <= 1;
        repeat (2) @(posedge clk_i);
        chk(src, 4'h1);
        reg_i <= 0;
      end
    end
    // Divider clamp, strobe spacing, ignored and unmapped writes
    boot(3'h5, 0, 0);
    wb(8'h08, 1, 32'h0);
    wb(8'h08, 0, 0);
    chk(rd, 32'h2);
    repeat (12) @(posedge clk_i);
    chk(gap, 8'h2);
    wb(8'h08, 1, 32'h5);
    repeat (20) @(posedge clk_i);
    chk(gap, 8'h5);
    sel <= 4'hE;
    wb(8'h08, 1, 32'h9);
    sel <= 4'hF;
    wb(8'h08, 0, 0);
    chk(rd, 32'h5);
    wb(8'h00, 1, 32'h3);
    wb(8'h00, 0, 0);
    chk(rd, 32'h0);
    wb(8'hF0, 1, 32'h1);
    wb(8'hF0, 0, 0);
    chk(rd, 32'h0);
    results();
  end
endmodule

bind chip_mode_sel chip_mode_sel_monitor mon (.clk_i, .rst_i, .internal_region_i, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .data_src_o, .port_cfg_o, .debug_unit_en_o, .ext_bus_tick_o);
